// File: rtl/risc_core.sv
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module risc_core #(
  parameter int PC_W = core_pkg::PC_W_DEFAULT
) (
  input  wire logic                           clock,
  input  wire logic                           srst,
  input  wire logic                           master_clear_n,
  // Internal program memory port
  output logic [PC_W-1:0]                     prog_addr,
  input  wire logic [core_pkg::INSTR_W-1:0]   prog_data,
  output logic                                secondary_osc_pin,
  // Classic Wishbone slave
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [3:0]                     adr_i,
  input  wire logic [3:0]                     sel_i,
  input  wire logic [31:0]                    dat_i,
  output logic [31:0]                         dat_o,
  output logic                                ack_o
);

  initial begin
    if (PC_W < 9 || PC_W > 11) begin
      $error("PC_W must be 9, 10 or 11");
    end
  end

  // ==========================================================
  // Declarations
  // ==========================================================
  logic                                 clear_meta;
  logic                                 clear_sync;
  logic                                 run;
  logic                                 rc_mode;
  logic                                 core_rst;
  core_pkg::phase_e                     phase;
  logic                                 instr_rate_clock_out;
  logic [core_pkg::INSTR_W-1:0]         ir;
  logic [PC_W-1:0]                      pc;
  logic [PC_W-1:0]                      stack0;
  logic [PC_W-1:0]                      stack1;
  logic [7:0]                           acc;
  logic [7:0]                           status;
  logic [7:0]                           pointer;
  logic [7:0]                           file_mem [core_pkg::FILE_DEPTH];
  logic                                 exec;
  logic [core_pkg::FILE_ADDR_W-1:0]     fa;
  logic [7:0]                           rd;
  logic [7:0]                           res;
  logic                                 wr_f;
  logic                                 wr_w;
  logic                                 upd_z;
  logic                                 upd_c;
  logic                                 upd_dc;
  logic                                 c_v;
  logic                                 dc_v;
  logic                                 skip;
  logic                                 jump;
  logic                                 push;
  logic                                 pop;
  logic [PC_W-1:0]                      jtarget;
  logic [7:0]                           mask;
  logic [8:0]                           add9;
  logic [8:0]                           sub9;
  logic [4:0]                           add5;
  logic [4:0]                           sub5;
  logic [10:0]                          goto11;
  logic [10:0]                          call11;
  logic [10:0]                          pcl11;
  logic                                 bus_req;
  logic [PC_W-1:0]                      pc_inc;

  // ==========================================================
  // Master clear synchroniser and core reset
  // ==========================================================
  always_ff @(posedge clock) begin
    if (srst) begin
      clear_meta <= 1'b0;
      clear_sync <= 1'b0;
    end else begin
      clear_meta <= master_clear_n;
      clear_sync <= clear_meta;
    end
  end

  // Bus register writes still work while the core is held
  assign core_rst = srst | ~clear_sync | ~run;

  // ==========================================================
  // Wishbone slave
  // ==========================================================
  assign bus_req = cyc_i & stb_i & ~ack_o;

  always_ff @(posedge clock) begin
    if (srst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      run     <= core_pkg::CTRL_RUN_RESET;
      rc_mode <= core_pkg::CTRL_RC_RESET;
    // Write lands at the edge where the master sees ack, while the request still stands
    end else if (cyc_i && stb_i && ack_o && we_i && sel_i[0] && adr_i == core_pkg::CTRL_OFFSET) begin
      run     <= dat_i[core_pkg::CTRL_RUN_BIT];
      rc_mode <= dat_i[core_pkg::CTRL_RC_MODE_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      unique case (adr_i)
        core_pkg::CTRL_OFFSET:      dat_o <= {30'h0000_0000, rc_mode, run};
        core_pkg::PC_VIEW_OFFSET:   dat_o <= 32'(pc);
        core_pkg::CORE_VIEW_OFFSET: dat_o <= {16'h0000, status, acc};
        default:                    dat_o <= 32'h0000_0000;
      endcase
    end else begin
      dat_o <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Quarter-rate phase counter and instruction clock out
  // ==========================================================
  always_ff @(posedge clock) begin
    if (core_rst) begin
      phase <= core_pkg::PH_Q1;
    end else begin
      phase <= core_pkg::phase_e'(phase + 2'b01);
    end
  end

  // Output is high in the second half of each instruction cycle
  always_ff @(posedge clock) begin
    if (core_rst) begin
      instr_rate_clock_out <= 1'b0;
    end else begin
      instr_rate_clock_out <= rc_mode & (phase == core_pkg::PH_Q2 || phase == core_pkg::PH_Q3);
    end
  end

  assign secondary_osc_pin = instr_rate_clock_out;

  // Execute and fetch-latch happen together on the last phase
  assign exec = (phase == core_pkg::PH_Q4);

  // ==========================================================
  // Operand fetch
  // ==========================================================
  // Address zero selects the pointer: indirect access
  assign fa = (ir[4:0] == core_pkg::INDIRECT_ADDR) ? pointer[4:0] : ir[4:0];

  always_comb begin
    unique case (fa)
      core_pkg::INDIRECT_ADDR: rd = 8'h00;
      core_pkg::PC_LOW_ADDR:   rd = pc[7:0];
      core_pkg::STATUS_ADDR:   rd = status;
      core_pkg::POINTER_ADDR:  rd = pointer;
      default:                 rd = file_mem[fa];
    endcase
  end

  assign add9   = {1'b0, rd} + {1'b0, acc};
  assign sub9   = {1'b0, rd} + {1'b0, ~acc} + 9'h001;
  assign add5   = {1'b0, rd[3:0]} + {1'b0, acc[3:0]};
  assign sub5   = {1'b0, rd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  assign mask   = 8'h01 << ir[7:5];
  assign goto11 = {status[core_pkg::PAGE_HI_BIT:core_pkg::PAGE_LO_BIT], ir[8:0]};
  assign call11 = {status[core_pkg::PAGE_HI_BIT:core_pkg::PAGE_LO_BIT], 1'b0, ir[7:0]};
  assign pcl11  = {status[core_pkg::PAGE_HI_BIT:core_pkg::PAGE_LO_BIT], 1'b0, res};
  assign pc_inc = pc + {{(PC_W-1){1'b0}}, 1'b1};

  // ==========================================================
  // Decode and ALU
  // ==========================================================
  always_comb begin
    res     = rd;
    wr_f    = 1'b0;
    wr_w    = 1'b0;
    upd_z   = 1'b0;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    c_v     = status[core_pkg::CARRY_BIT];
    dc_v    = status[core_pkg::NIBBLE_CARRY_BIT];
    skip    = 1'b0;
    jump    = 1'b0;
    push    = 1'b0;
    pop     = 1'b0;
    jtarget = pc;
    if (ir[11:10] == 2'b00) begin
      // Byte operations: bit 5 picks file or accumulator as destination
      wr_f = ir[5];
      wr_w = ~ir[5];
      unique case (ir[9:6])
        4'h0: begin
          if (ir[5]) begin
            res  = acc;
            wr_w = 1'b0;
          end else begin
            wr_w = 1'b0; // Housekeeping opcodes act as no-ops
          end
        end
        4'h1: begin
          res   = 8'h00;
          upd_z = 1'b1;
        end
        4'h2: begin
          res    = sub9[7:0];
          c_v    = sub9[8];
          dc_v   = sub5[4];
          upd_z  = 1'b1;
          upd_c  = 1'b1;
          upd_dc = 1'b1;
        end
        4'h3: begin
          res   = rd - 8'h01;
          upd_z = 1'b1;
        end
        4'h4: begin
          res   = rd | acc;
          upd_z = 1'b1;
        end
        4'h5: begin
          res   = rd & acc;
          upd_z = 1'b1;
        end
        4'h6: begin
          res   = rd ^ acc;
          upd_z = 1'b1;
        end
        4'h7: begin
          res    = add9[7:0];
          c_v    = add9[8];
          dc_v   = add5[4];
          upd_z  = 1'b1;
          upd_c  = 1'b1;
          upd_dc = 1'b1;
        end
        4'h8: begin
          res   = rd;
          upd_z = 1'b1;
        end
        4'h9: begin
          res   = ~rd;
          upd_z = 1'b1;
        end
        4'ha: begin
          res   = rd + 8'h01;
          upd_z = 1'b1;
        end
        4'hb: begin
          res  = rd - 8'h01;
          skip = (res == 8'h00);
        end
        4'hc: begin
          res   = {status[core_pkg::CARRY_BIT], rd[7:1]};
          c_v   = rd[0];
          upd_c = 1'b1;
        end
        4'hd: begin
          res   = {rd[6:0], status[core_pkg::CARRY_BIT]};
          c_v   = rd[7];
          upd_c = 1'b1;
        end
        4'he: res = {rd[3:0], rd[7:4]};
        4'hf: begin
          res  = rd + 8'h01;
          skip = (res == 8'h00);
        end
      endcase
    end else if (ir[11:10] == 2'b01) begin
      unique case (ir[9:8])
        2'b00: begin
          res  = rd & ~mask;
          wr_f = 1'b1;
        end
        2'b01: begin
          res  = rd | mask;
          wr_f = 1'b1;
        end
        2'b10: skip = ((rd & mask) == 8'h00);
        2'b11: skip = ((rd & mask) != 8'h00);
      endcase
    end else if (ir[11:9] == 3'b101) begin
      jump    = 1'b1;
      jtarget = goto11[PC_W-1:0];
    end else begin
      unique case (ir[11:8])
        4'h8: begin
          res     = ir[7:0];
          wr_w    = 1'b1;
          jump    = 1'b1;
          pop     = 1'b1;
          jtarget = stack0;
        end
        4'h9: begin
          jump    = 1'b1;
          push    = 1'b1;
          jtarget = call11[PC_W-1:0];
        end
        4'hc: begin
          res  = ir[7:0];
          wr_w = 1'b1;
        end
        4'hd: begin
          res   = ir[7:0] | acc;
          wr_w  = 1'b1;
          upd_z = 1'b1;
        end
        4'he: begin
          res   = ir[7:0] & acc;
          wr_w  = 1'b1;
          upd_z = 1'b1;
        end
        default: begin
          res   = ir[7:0] ^ acc;
          wr_w  = 1'b1;
          upd_z = 1'b1;
        end
      endcase
    end
    // A write to the low program counter is a computed jump
    if (wr_f && fa == core_pkg::PC_LOW_ADDR) begin
      jump    = 1'b1;
      jtarget = pcl11[PC_W-1:0];
    end
  end

  // ==========================================================
  // Fetch pipeline and program counter
  // ==========================================================
  always_ff @(posedge clock) begin
    if (core_rst) begin
      ir <= core_pkg::NOP_WORD;
    end else if (exec) begin
      // Flow change drops the prefetched word, costing a second cycle
      ir <= (jump || skip) ? core_pkg::NOP_WORD : prog_data;
    end
  end

  // Reset vector is the last program word
  always_ff @(posedge clock) begin
    if (core_rst) begin
      pc <= '1;
    end else if (exec) begin
      pc <= jump ? jtarget : pc_inc;
    end
  end

  // Address is held for all four phases of the cycle
  always_ff @(posedge clock) begin
    if (core_rst) begin
      prog_addr <= '1;
    end else begin
      prog_addr <= pc;
    end
  end

  // Two-level return stack
  always_ff @(posedge clock) begin
    if (core_rst) begin
      stack0 <= '0;
      stack1 <= '0;
    end else if (exec && push) begin
      stack0 <= pc;
      stack1 <= stack0;
    end else if (exec && pop) begin
      stack0 <= stack1;
    end
  end

  // ==========================================================
  // Accumulator, status, pointer and file storage
  // ==========================================================
  always_ff @(posedge clock) begin
    if (core_rst) begin
      acc <= core_pkg::ACC_RESET;
    end else if (exec && wr_w) begin
      acc <= res;
    end
  end

  // Flag updates land after a direct write to the status file
  always_ff @(posedge clock) begin
    if (core_rst) begin
      status <= core_pkg::STATUS_RESET;
    end else if (exec) begin
      if (wr_f && fa == core_pkg::STATUS_ADDR) begin
        status <= res;
      end
      if (upd_z) begin
        status[core_pkg::ZERO_BIT] <= (res == 8'h00);
      end
      if (upd_c) begin
        status[core_pkg::CARRY_BIT] <= c_v;
      end
      if (upd_dc) begin
        status[core_pkg::NIBBLE_CARRY_BIT] <= dc_v;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (core_rst) begin
      pointer <= core_pkg::POINTER_RESET;
    end else if (exec && wr_f && fa == core_pkg::POINTER_ADDR) begin
      pointer <= res;
    end
  end

  // General files are plain storage and keep contents over reset
  for (genvar i = 0; i < core_pkg::FILE_DEPTH; i++) begin : g_file
    always_ff @(posedge clock) begin
      if (!core_rst && exec && wr_f && fa == core_pkg::FILE_ADDR_W'(i)) begin
        file_mem[i] <= res;
      end
    end
  end

endmodule : risc_core

// File: common/core_pkg.sv
package core_pkg;

  // ==========================================================
  // Register bus map (byte addresses)
  // ==========================================================
  localparam logic [3:0] CTRL_OFFSET       = 4'h0;
  localparam logic [3:0] PC_VIEW_OFFSET    = 4'h4;
  localparam logic [3:0] CORE_VIEW_OFFSET  = 4'h8;
  localparam int         CTRL_RUN_BIT      = 0;
  localparam int         CTRL_RC_MODE_BIT  = 1;
  localparam logic       CTRL_RUN_RESET    = 1'b1;
  localparam logic       CTRL_RC_RESET     = 1'b0;

  // ==========================================================
  // Data memory map
  // ==========================================================
  localparam int         FILE_ADDR_W       = 5;
  localparam int         FILE_DEPTH        = 32;
  localparam logic [4:0] INDIRECT_ADDR     = 5'h00;
  localparam logic [4:0] PC_LOW_ADDR       = 5'h02;
  localparam logic [4:0] STATUS_ADDR       = 5'h03;
  localparam logic [4:0] POINTER_ADDR      = 5'h04;

  // Status register fields
  localparam int         CARRY_BIT         = 0;
  localparam int         NIBBLE_CARRY_BIT  = 1;
  localparam int         ZERO_BIT          = 2;
  localparam int         PAGE_LO_BIT       = 5;
  localparam int         PAGE_HI_BIT       = 6;
  localparam logic [7:0] STATUS_RESET      = 8'h18;
  localparam logic [7:0] POINTER_RESET     = 8'h00;
  localparam logic [7:0] ACC_RESET         = 8'h00;

  // ==========================================================
  // Instruction format and timing
  // ==========================================================
  localparam int          INSTR_W          = 12;
  localparam logic [11:0] NOP_WORD         = 12'h000;
  localparam int          PC_W_DEFAULT     = 11;
  localparam int          OSC_PER_CYCLE    = 4;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_e;

endpackage : core_pkg

// File: dv/prog_mem_model.sv
`timescale 1ns/1ps
module prog_mem_model #(
  parameter int AW      = 9,
  parameter bit LATENCY = 1'b1
) (
  input  wire logic                         clock,
  input  wire logic [AW-1:0]                addr,
  output logic [core_pkg::INSTR_W-1:0]      data
);
  // ==========================================================
  // On-chip word store, one instruction per location
  // ==========================================================
  logic [core_pkg::INSTR_W-1:0] mem [2**AW];
  logic [core_pkg::INSTR_W-1:0] held;

  initial for (int i = 0; i < 2**AW; i++) mem[i] = core_pkg::NOP_WORD;

  // Slow answer spends one of the two clocks the core allows before Q4
  always_ff @(posedge clock) held <= mem[addr];
  assign data = LATENCY ? held : mem[addr];
endmodule : prog_mem_model

// File: dv/core_chk.sv
`timescale 1ns/1ps
module core_chk #(
  parameter int PC_W = 11
) (
  input wire logic                          clock,
  input wire logic                          srst,
  input wire logic                          master_clear_n,
  input wire logic [PC_W-1:0]               prog_addr,
  input wire logic [core_pkg::INSTR_W-1:0]  prog_data,
  input wire logic                          secondary_osc_pin,
  input wire logic                          cyc_i,
  input wire logic                          stb_i,
  input wire logic                          we_i,
  input wire logic [3:0]                    adr_i,
  input wire logic [3:0]                    sel_i,
  input wire logic [31:0]                   dat_i,
  input wire logic [31:0]                   dat_o,
  input wire logic                          ack_o
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic mapped;
  assign mapped = adr_i inside {core_pkg::CTRL_OFFSET, core_pkg::PC_VIEW_OFFSET, core_pkg::CORE_VIEW_OFFSET};
  // ==========================================================
  // Register bus
  // ==========================================================
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack_o stood longer than one cycle");
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in the next cycle");
  chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_unmapped_zero: assert property (ack_o && !we_i && !mapped |-> dat_o == 32'h0)
    else $error("unmapped read returned nonzero");
  chk_core_view_upper: assert property (ack_o && !we_i && adr_i == core_pkg::CORE_VIEW_OFFSET
                                        |-> dat_o[31:16] == 16'h0)
    else $error("core view upper half not zero");
  // ==========================================================
  // Fetch timing and reset
  // ==========================================================
  // A core reset forces the reset vector and may cut a word short, so all ones is allowed
  chk_addr_hold: assert property ($changed(prog_addr) |=> ($stable(prog_addr) || &prog_addr)[*3])
    else $error("program address held under four clocks");
  chk_master_clear_n_reset: assert property (!master_clear_n [*4] |=> &prog_addr)
    else $error("master clear low did not reset fetch address");
  chk_osc_high_max: assert property ($rose(secondary_osc_pin) |=> ##1 !secondary_osc_pin)
    else $error("rate clock high longer than two clocks");
  chk_osc_low_min: assert property ($fell(secondary_osc_pin) |=> !secondary_osc_pin)
    else $error("rate clock low shorter than two clocks");
  cov_core_read: cover property (ack_o && !we_i && adr_i == core_pkg::CORE_VIEW_OFFSET);
  cov_osc_rise: cover property ($rose(secondary_osc_pin));
  cov_master_clear_n: cover property (!master_clear_n [*4]);
endmodule : core_chk

bind risc_core core_chk #(.PC_W(PC_W)) u_chk (
  .clock(clock), .srst(srst), .master_clear_n(master_clear_n), .prog_addr(prog_addr),
  .prog_data(prog_data), .secondary_osc_pin(secondary_osc_pin), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o)
);

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int PW = 9;
  typedef struct packed {
    logic [6:0] opd;
    logic [4:0] f;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] acc;
    logic [7:0] st;
  } row_s;
  logic        clock          = 1'b0;
  logic        srst           = 1'b1;
  logic        master_clear_n = 1'b1;
  logic        cyc            = 1'b0;
  logic        stb            = 1'b0;
  logic        we             = 1'b0;
  logic [3:0]  adr            = 4'h0;
  logic [3:0]  sel            = 4'h0;
  logic [31:0] wdat           = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        osc;
  logic [PW-1:0] pa;
  logic [11:0] pd;
  logic [31:0] q;
  int          miscompares     = 0;
  int          samples_checked = 0;
  // File 8 holds a, acc holds b; file 0 reaches file 8 through the pointer
  row_s rows [16] = '{
    '{7'h0e, 5'h08, 8'h08, 8'h08, 8'h10, 8'h1a}, '{7'h0e, 5'h00, 8'h80, 8'h80, 8'h00, 8'h1d},
    '{7'h04, 5'h08, 8'h05, 8'h06, 8'hff, 8'h18}, '{7'h04, 5'h08, 8'h10, 8'h01, 8'h0f, 8'h19},
    '{7'h04, 5'h00, 8'h22, 8'h22, 8'h00, 8'h1f}, '{7'h0a, 5'h08, 8'hf0, 8'h3c, 8'h30, 8'h18},
    '{7'h0c, 5'h00, 8'h5a, 8'h5a, 8'h00, 8'h1c}, '{7'h18, 5'h08, 8'h03, 8'h00, 8'h01, 8'h19},
    '{7'h1c, 5'h08, 8'h3c, 8'h00, 8'hc3, 8'h18}, '{7'h12, 5'h08, 8'hff, 8'h00, 8'h00, 8'h1c},
    '{7'h14, 5'h00, 8'hff, 8'h00, 8'h00, 8'h1c}, '{7'h08, 5'h08, 8'h00, 8'h00, 8'h00, 8'h1c},
    '{7'h06, 5'h08, 8'h01, 8'h00, 8'h00, 8'h1c}, '{7'h1a, 5'h08, 8'h81, 8'h00, 8'h02, 8'h19},
    '{7'h10, 5'h08, 8'h00, 8'h55, 8'h00, 8'h1c}, '{7'h15, 5'h08, 8'h41, 8'h77, 8'h77, 8'h18}};

  always #5 clock = ~clock;

  risc_core #(.PC_W(PW)) DUT (
    .clock(clock), .srst(srst), .master_clear_n(master_clear_n), .prog_addr(pa), .prog_data(pd),
    .secondary_osc_pin(osc), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack));
  prog_mem_model #(.AW(PW), .LATENCY(1'b1)) prog (.clock(clock), .addr(pa), .data(pd));

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    adr  <= a;
    we   <= w;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      check("bus_ack", 32'h1, 32'(ack));
      complete_run();
    end
  endtask : wb

  task automatic run_row(input row_s r);
    logic [PW-1:0] last;
    int            seq [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 6, 7};
    int            len;
    int            k;
    wb(core_pkg::CTRL_OFFSET, 1'b1, 32'h0, 4'h1);
    prog.mem[9'h1ff] = 12'ha00;
    prog.mem[0] = 12'hc08;
    prog.mem[1] = 12'h024;
    prog.mem[2] = {4'hc, r.a};
    prog.mem[3] = 12'h028;
    prog.mem[4] = {4'hc, r.b};
    prog.mem[5] = {r.opd, r.f};
    prog.mem[6] = 12'ha06;
    wb(core_pkg::CTRL_OFFSET, 1'b1, 32'h1, 4'h1);
    last = pa;
    k = 0;
    len = 0;
    for (int t = 0; t < 200 && k < 10; t++) begin
      @(posedge clock);
      len++;
      if (pa !== last) begin
        check("prog_addr", 32'(seq[k]), 32'(pa));
        if (k > 0) check("word_clocks", (k == 1) ? 32'd8 : 32'd4, 32'(len));
        k++;
        len = 0;
        last = pa;
      end
    end
    if (k < 10) begin
      check("fetch_count", 32'd10, 32'(k));
      complete_run();
    end
    wb(core_pkg::CORE_VIEW_OFFSET, 1'b0, 32'h0, 4'hf);
    check("core_view", {16'h0, r.st, r.acc}, q);
  endtask : run_row

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    int            n;
    logic          prev;
    logic [PW-1:0] pl;
    repeat (3) @(posedge clock);
    check("prog_addr_reset", 32'h1ff, 32'(pa));
    @(posedge clock);
    srst <= 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    master_clear_n <= 1'b0;
    repeat (8) @(posedge clock);
    check("prog_addr_master_clear_n", 32'h1ff, 32'(pa));
    wb(core_pkg::CORE_VIEW_OFFSET, 1'b0, 32'h0, 4'hf);
    check("core_view_master_clear_n", 32'h1800, q);
    master_clear_n <= 1'b1;
    wb(core_pkg::CTRL_OFFSET, 1'b1, 32'h3, 4'h1);
    repeat (16) @(posedge clock);
    n = 0;
    prev = osc;
    repeat (40) begin
      @(posedge clock);
      if (osc === 1'b1 && prev === 1'b0) n++;
      prev = osc;
    end
    check("osc_rises", 32'd10, 32'(n));
    wb(core_pkg::CTRL_OFFSET, 1'b1, 32'h1, 4'h1);
    repeat (2) @(posedge clock);
    n = 0;
    repeat (8) begin
      @(posedge clock);
      if (osc !== 1'b0) n++;
    end
    check("osc_off_high", 32'd0, 32'(n));
    // Byte lane off: the stop request must be ignored
    wb(core_pkg::CTRL_OFFSET, 1'b1, 32'h0, 4'h0);
    n = 0;
    pl = pa;
    repeat (12) begin
      @(posedge clock);
      if (pa !== pl) n++;
      pl = pa;
    end
    check("addr_moves", 32'd3, 32'(n));
    wb(core_pkg::PC_VIEW_OFFSET, 1'b0, 32'h0, 4'hf);
    check("pc_view", {29'h0, 2'b11, q[0]}, q);
    wb(4'hc, 1'b1, 32'hffffffff, 4'hf);
    wb(4'hc, 1'b0, 32'h0, 4'hf);
    check("unmapped", 32'h0, q);
    complete_run();
  end
endmodule : testbench
